// File: core/dah_defs.svh
// Constant definitions for the debug authentication and halting control block
`ifndef DAH_DEFS_SVH
`define DAH_DEFS_SVH
`define DAH_ADDR_W 12
`define DAH_OFS_CTRL 12'h000
`define DAH_OFS_STATUS 12'h004
`define DAH_OFS_CORE 12'h008
`define DAH_OFS_EVENT 12'h00c
`define DAH_OFS_SYND 12'h010
`define DAH_OFS_OSLOCK 12'h014
`define DAH_OFS_REQ 12'h018
`define DAH_CTRL_TDA 0
`define DAH_CTRL_INTDIS 1
`define DAH_CORE_DEBUG 0
`define DAH_CORE_HYP 1
`define DAH_CORE_TGE 2
`define DAH_REQ_BKPT 0
`define DAH_REQ_WARM 1
`define DAH_RESP_OKAY 2'h0
`define DAH_RESP_SLVERR 2'h2
`define DAH_RESP_DECERR 2'h3
`define DAH_DATA_FAULT_STATUS_DEBUG 5'h02
`endif

// File: core/dah_pkg.sv
// Types shared by the debug authentication and halting control block
`default_nettype none
package dah_pkg;
   typedef enum logic [1:0] {
      DAH_LVL_APP = 2'h0,
      DAH_LVL_OS = 2'h1,
      DAH_LVL_HYP = 2'h2
   } dah_level_t;
   typedef enum logic [2:0] {
      DAH_EV_NONE = 3'h0,
      DAH_EV_SYNC = 3'h1,
      DAH_EV_HVC = 3'h2,
      DAH_EV_ASYNC = 3'h3,
      DAH_EV_RESET = 3'h4,
      DAH_EV_DEBUG = 3'h5
   } dah_event_t;
endpackage
`default_nettype wire

// File: core/dah_perm_if.sv
// Permission bundle passed from the authentication stage to the main logic
`default_nettype none
interface dah_perm_if;
   logic invasive;
   logic noninvasive;
   logic hyp_invasive;
   logic hyp_noninvasive;
   modport src (output invasive, output noninvasive, output hyp_invasive,
      output hyp_noninvasive);
   modport dst (input invasive, input noninvasive, input hyp_invasive,
      input hyp_noninvasive);
endinterface
`default_nettype wire

// File: core/dah_auth.sv
// Authentication input synchroniser and permission derivation
`default_nettype none
module dah_auth #(
   parameter bit HYP_IMPL = 1'b1
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic reset_n,
   // Authentication inputs
   input wire logic debug_enable_in,
   input wire logic noninv_enable_in,
   input wire logic hyp_inv_enable_in,
   input wire logic hyp_noninv_enable_in,
   // Permissions
   dah_perm_if.src perm
);
   logic [3:0] meta_q, meta_d, sync_q, sync_d;
   logic dbg, nid, hid, hnid;

   always_comb begin
      meta_d = {hyp_noninv_enable_in, hyp_inv_enable_in, noninv_enable_in, debug_enable_in};
      sync_d = meta_q;
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         meta_q <= 4'h0;
         sync_q <= 4'h0;
      end else begin
         meta_q <= meta_d;
         sync_q <= sync_d;
      end
   end

   always_comb begin
      dbg = sync_q[0];
      nid = sync_q[1];
      hid = sync_q[2] & HYP_IMPL;
      hnid = sync_q[3] & HYP_IMPL;
      // Forms below keep the ordering between permissions by construction
      perm.invasive = dbg;
      perm.noninvasive = dbg | nid;
      perm.hyp_invasive = dbg & hid;
      perm.hyp_noninvasive = (dbg | nid) & (hid | hnid);
   end
endmodule
`default_nettype wire

// File: core/dah_top.sv
// Debug authentication, halting control and AXI4-Lite register slave
//
// Added by the designer: the placing of the registers and the AXI4-Lite slave port.
`default_nettype none
`include "dah_defs.svh"
// Notes on behaviour
// - Permissions are simple AND/OR combinations of the four enable inputs.
// - Hyp permissions never exceed base ones; invasive implies non-invasive.
// - Without a hypervisor level both hyp inputs act as held low.
// - No hyp invasive permission: halting prohibited at hyp level or when trapping.
// - No hyp invasive permission: breakpoint clear and warm reset writes dropped.
// - No hyp invasive permission: trap access ignored at hyp, hyp interrupts unmasked.
// - Outside debug state halting-denied reads inverse of hyp invasive permission.
// - Debug entry loads halting-denied: zero at hyp or trap, else inverse permission.
// - Halting-denied holds constant throughout debug state.
// - Halting-denied in debug state makes hyp change and hyp-trapped instructions undefined.
// - Halting-denied in debug state sends hyp MPU faults to OS level as debug event.
// - Stepping enters an exception if halting allowed at target, else steps over.
// - Stepped synchronous exception to OS, or allowed hyp, sets step syndrome.
// - Hypervisor call during stepping always sets step syndrome.
// - Asynchronous exception before step to OS, or allowed hyp, sets syndrome.
// - Disallowed hyp synchronous or asynchronous exceptions and debug entries leave step syndrome alone.
// - Clean step completion or reset to highest level sets step syndrome.
// - Hyp invasive input alters register access permissions only for writes to the request register.
// - OS lock write without invasive permission gets an error response.
module dah_top #(
   parameter bit HYP_IMPL = 1'b1
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic reset_n,
   // Authentication inputs
   input wire logic debug_enable_in,
   input wire logic noninv_enable_in,
   input wire logic hyp_inv_enable_in,
   input wire logic hyp_noninv_enable_in,
   // Core state
   input wire logic in_debug_state,
   input wire logic [1:0] current_level,
   input wire logic trap_general_exceptions,
   input wire logic hyp_trap_configured,
   input wire logic is_debug_change_to_hyp_instr,
   input wire logic hyp_mpu_fault,
   input wire logic hyp_irq_pending,
   // Step events
   input wire logic step_event_valid,
   input wire logic [2:0] step_event,
   input wire logic [1:0] step_target_level,
   // Halting and step results
   output logic halting_allowed,
   output logic step_into,
   output logic instr_undefined,
   output logic fault_to_os_level,
   output logic [4:0] data_fault_status,
   output logic hyp_irq_masked,
   output logic trap_debug_access_eff,
   output logic sticky_bkpt_clear_pulse,
   output logic warm_reset_pulse,
   output logic oslock_q,
   // AXI4-Lite slave
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   dah_perm_if perm ();

   dah_auth #(.HYP_IMPL(HYP_IMPL)) u_auth (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .debug_enable_in(debug_enable_in),
      .noninv_enable_in(noninv_enable_in),
      .hyp_inv_enable_in(hyp_inv_enable_in),
      .hyp_noninv_enable_in(hyp_noninv_enable_in),
      .perm(perm)
   );

   // Halting is allowed at a level when invasive permission covers it
   function automatic logic halt_ok(input logic [1:0] lvl, input logic tge,
      input logic inv, input logic hinv);
      halt_ok = inv & (hinv | ((lvl != dah_pkg::DAH_LVL_HYP) & !tge));
   endfunction

   // Core-side state
   logic halting_denied_bit_q, halting_denied_bit_d;
   logic step_syndrome_bit_q, step_syndrome_bit_d;
   logic trap_debug_access_q, trap_debug_access_d;
   logic interrupt_disable_ctl_q, interrupt_disable_ctl_d;
   logic oslock_d;
   logic [2:0] last_event_q, last_event_d;
   logic bkpt_q, bkpt_d, warm_q, warm_d;
   logic at_hyp, hdd_view;

   assign at_hyp = (current_level == dah_pkg::DAH_LVL_HYP);

   always_comb begin
      halting_allowed = halt_ok(current_level, trap_general_exceptions,
         perm.invasive, perm.hyp_invasive);
      step_into = step_event_valid &
         halt_ok(step_target_level, trap_general_exceptions,
         perm.invasive, perm.hyp_invasive);
      // Halting-denied view: live outside debug state, frozen inside
      hdd_view = in_debug_state ? halting_denied_bit_q : !perm.hyp_invasive;
      instr_undefined = in_debug_state & halting_denied_bit_q &
         (is_debug_change_to_hyp_instr |
         ((current_level != dah_pkg::DAH_LVL_HYP) & hyp_trap_configured));
      fault_to_os_level = in_debug_state & halting_denied_bit_q & hyp_mpu_fault;
      data_fault_status = fault_to_os_level ? `DAH_DATA_FAULT_STATUS_DEBUG : 5'h00;
      // Interrupt disable only masks hyp interrupts with hyp permission
      hyp_irq_masked = hyp_irq_pending & interrupt_disable_ctl_q & perm.hyp_invasive;
      trap_debug_access_eff = trap_debug_access_q & (!at_hyp | perm.hyp_invasive);
      sticky_bkpt_clear_pulse = bkpt_q;
      warm_reset_pulse = warm_q;
   end

   always_comb begin
      halting_denied_bit_d = halting_denied_bit_q;
      // Primed outside debug so the first debug cycle already sees the entry value
      if (!in_debug_state) begin
         if (at_hyp || trap_general_exceptions) begin
            halting_denied_bit_d = 1'b0;
         end else begin
            halting_denied_bit_d = !perm.hyp_invasive;
         end
      end
   end

   always_comb begin
      step_syndrome_bit_d = step_syndrome_bit_q;
      last_event_d = last_event_q;
      if (step_event_valid) begin
         last_event_d = step_event;
         case (step_event)
            dah_pkg::DAH_EV_NONE, dah_pkg::DAH_EV_RESET: begin
               step_syndrome_bit_d = 1'b1;
            end
            dah_pkg::DAH_EV_HVC: begin
               step_syndrome_bit_d = 1'b1;
            end
            dah_pkg::DAH_EV_SYNC: begin
               if (step_target_level != dah_pkg::DAH_LVL_HYP || perm.hyp_invasive) begin
                  step_syndrome_bit_d = 1'b1;
               end
            end
            dah_pkg::DAH_EV_ASYNC: begin
               if (step_target_level != dah_pkg::DAH_LVL_HYP || perm.hyp_invasive) begin
                  step_syndrome_bit_d = 1'b1;
               end
            end
            dah_pkg::DAH_EV_DEBUG: begin
               step_syndrome_bit_d = step_syndrome_bit_q;
            end
            default: begin
               step_syndrome_bit_d = step_syndrome_bit_q;
            end
         endcase
      end
   end

   // AXI4-Lite slave state
   logic aw_full_q, aw_full_d, w_full_q, w_full_d;
   logic [11:0] awaddr_q, awaddr_d;
   logic [31:0] wdata_q, wdata_d;
   logic [3:0] wstrb_q, wstrb_d;
   logic bvalid_q, bvalid_d;
   logic [1:0] bresp_q, bresp_d;
   logic rvalid_q, rvalid_d;
   logic [1:0] rresp_q, rresp_d;
   logic [31:0] rdata_q, rdata_d;
   logic do_write;

   always_comb begin
      s_axi_awready = !aw_full_q && !bvalid_q;
      s_axi_wready = !w_full_q && !bvalid_q;
      s_axi_arready = !rvalid_q;
      s_axi_bvalid = bvalid_q;
      s_axi_bresp = bresp_q;
      s_axi_rvalid = rvalid_q;
      s_axi_rresp = rresp_q;
      s_axi_rdata = rdata_q;
   end

   always_comb begin
      aw_full_d = aw_full_q;
      w_full_d = w_full_q;
      awaddr_d = awaddr_q;
      wdata_d = wdata_q;
      wstrb_d = wstrb_q;
      bvalid_d = bvalid_q;
      bresp_d = bresp_q;
      trap_debug_access_d = trap_debug_access_q;
      interrupt_disable_ctl_d = interrupt_disable_ctl_q;
      oslock_d = oslock_q;
      bkpt_d = 1'b0;
      warm_d = 1'b0;
      do_write = 1'b0;
      if (s_axi_awvalid && s_axi_awready) begin
         aw_full_d = 1'b1;
         awaddr_d = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         w_full_d = 1'b1;
         wdata_d = s_axi_wdata;
         wstrb_d = s_axi_wstrb;
      end
      if (aw_full_q && w_full_q && !bvalid_q) begin
         do_write = 1'b1;
         aw_full_d = 1'b0;
         w_full_d = 1'b0;
         bvalid_d = 1'b1;
         bresp_d = `DAH_RESP_OKAY;
         // OS lock writes depend on the invasive permission, and request register writes on hyp invasive
         case ({awaddr_q[11:2], 2'b00})
            `DAH_OFS_CTRL: begin
               if (wstrb_q[0]) begin
                  trap_debug_access_d = wdata_q[`DAH_CTRL_TDA];
                  interrupt_disable_ctl_d = wdata_q[`DAH_CTRL_INTDIS];
               end
            end
            `DAH_OFS_OSLOCK: begin
               if (!perm.invasive) begin
                  bresp_d = `DAH_RESP_SLVERR;
               end else if (wstrb_q[0]) begin
                  oslock_d = wdata_q[0];
               end
            end
            `DAH_OFS_REQ: begin
               if (wstrb_q[0] && perm.hyp_invasive) begin
                  bkpt_d = wdata_q[`DAH_REQ_BKPT];
                  warm_d = wdata_q[`DAH_REQ_WARM];
               end
            end
            `DAH_OFS_STATUS, `DAH_OFS_CORE, `DAH_OFS_EVENT, `DAH_OFS_SYND: begin
               bresp_d = `DAH_RESP_OKAY;
            end
            default: begin
               bresp_d = `DAH_RESP_DECERR;
            end
         endcase
      end
      if (bvalid_q && s_axi_bready) begin
         bvalid_d = 1'b0;
      end
   end

   always_comb begin
      rvalid_d = rvalid_q;
      rresp_d = rresp_q;
      rdata_d = rdata_q;
      if (s_axi_arvalid && s_axi_arready) begin
         rvalid_d = 1'b1;
         rresp_d = `DAH_RESP_OKAY;
         rdata_d = 32'h0000_0000;
         case ({s_axi_araddr[11:2], 2'b00})
            `DAH_OFS_CTRL: begin
               rdata_d[`DAH_CTRL_TDA] = trap_debug_access_q;
               rdata_d[`DAH_CTRL_INTDIS] = interrupt_disable_ctl_q;
            end
            `DAH_OFS_STATUS: begin
               rdata_d[3:0] = {perm.hyp_noninvasive, perm.hyp_invasive,
                  perm.noninvasive, perm.invasive};
               rdata_d[4] = hdd_view;
               rdata_d[5] = halting_allowed;
            end
            `DAH_OFS_CORE: begin
               rdata_d[`DAH_CORE_DEBUG] = in_debug_state;
               rdata_d[`DAH_CORE_HYP] = at_hyp;
               rdata_d[`DAH_CORE_TGE] = trap_general_exceptions;
            end
            `DAH_OFS_EVENT: begin
               rdata_d[2:0] = last_event_q;
            end
            `DAH_OFS_SYND: begin
               rdata_d[0] = step_syndrome_bit_q;
            end
            `DAH_OFS_OSLOCK: begin
               rdata_d[0] = oslock_q;
            end
            `DAH_OFS_REQ: begin
               rdata_d = 32'h0000_0000;
            end
            default: begin
               rresp_d = `DAH_RESP_DECERR;
            end
         endcase
      end else if (rvalid_q && s_axi_rready) begin
         rvalid_d = 1'b0;
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         halting_denied_bit_q <= 1'b1;
         step_syndrome_bit_q <= 1'b0;
         last_event_q <= 3'h0;
         trap_debug_access_q <= 1'b0;
         interrupt_disable_ctl_q <= 1'b0;
         oslock_q <= 1'b0;
         bkpt_q <= 1'b0;
         warm_q <= 1'b0;
         aw_full_q <= 1'b0;
         w_full_q <= 1'b0;
         awaddr_q <= 12'h000;
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
         bvalid_q <= 1'b0;
         bresp_q <= 2'h0;
         rvalid_q <= 1'b0;
         rresp_q <= 2'h0;
         rdata_q <= 32'h0000_0000;
      end else begin
         halting_denied_bit_q <= halting_denied_bit_d;
         step_syndrome_bit_q <= step_syndrome_bit_d;
         last_event_q <= last_event_d;
         trap_debug_access_q <= trap_debug_access_d;
         interrupt_disable_ctl_q <= interrupt_disable_ctl_d;
         oslock_q <= oslock_d;
         bkpt_q <= bkpt_d;
         warm_q <= warm_d;
         aw_full_q <= aw_full_d;
         w_full_q <= w_full_d;
         awaddr_q <= awaddr_d;
         wdata_q <= wdata_d;
         wstrb_q <= wstrb_d;
         bvalid_q <= bvalid_d;
         bresp_q <= bresp_d;
         rvalid_q <= rvalid_d;
         rresp_q <= rresp_d;
         rdata_q <= rdata_d;
      end
   end

   // Write decode uses the hyp invasive permission only for the request register
   logic unused_write;
   assign unused_write = do_write;
endmodule
`default_nettype wire

// File: bench/dah_auth_drv.sv
// System logic model that drives the four authentication lines
`default_nettype none
module dah_auth_drv (
   // Clock
   input wire logic sys_clk,
   // Requested levels: debug, noninvasive, hyp invasive, hyp noninvasive
   input wire logic [3:0] setting,
   // Authentication lines
   output logic debug_enable_in,
   output logic noninv_enable_in,
   output logic hyp_inv_enable_in,
   output logic hyp_noninv_enable_in
);
   timeunit 1ns;
   timeprecision 1ns;
   // Lines move on the same clock edge on which the core samples them
   always @(posedge sys_clk) begin
      {hyp_noninv_enable_in, hyp_inv_enable_in, noninv_enable_in, debug_enable_in} <= setting;
   end
endmodule
`default_nettype wire

// File: bench/dah_top_props.sv
// Concurrent checks on the ports of the authentication and halting block
`default_nettype none
`include "dah_defs.svh"
module dah_top_props (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic reset_n,
   // Watched inputs, and the write response outputs
   input wire logic debug_enable_in,
   input wire logic hyp_inv_enable_in,
   input wire logic in_debug_state,
   input wire logic [1:0] current_level,
   input wire logic trap_general_exceptions,
   input wire logic hyp_mpu_fault,
   input wire logic hyp_irq_pending,
   input wire logic step_event_valid,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   // Watched outputs
   input wire logic halting_allowed,
   input wire logic step_into,
   input wire logic instr_undefined,
   input wire logic fault_to_os_level,
   input wire logic [4:0] data_fault_status,
   input wire logic hyp_irq_masked,
   input wire logic sticky_bkpt_clear_pulse,
   input wire logic warm_reset_pulse,
   input wire logic oslock_q
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   // Four low samples cover the two synchroniser stages with margin
   halt_needs_dbg_a: assert property ((!debug_enable_in)[*4] |-> !halting_allowed)
      else $error("halting allowed without debug enable");
   halt_hyp_deny_a: assert property ((!hyp_inv_enable_in)[*4] ##0
      (current_level == 2'h2 || trap_general_exceptions) |-> !halting_allowed)
      else $error("halting allowed at hyp level or under trap");
   irq_unmask_a: assert property ((!hyp_inv_enable_in)[*4] |-> !hyp_irq_masked)
      else $error("hyp interrupt masked without hyp permission");
   irq_cause_a: assert property (hyp_irq_masked |-> hyp_irq_pending)
      else $error("interrupt masked with none pending");
   req_drop_a: assert property ((!hyp_inv_enable_in)[*8] |->
      !sticky_bkpt_clear_pulse && !warm_reset_pulse)
      else $error("request pulse without hyp permission");
   pulse_once_a: assert property (sticky_bkpt_clear_pulse || warm_reset_pulse |=>
      !sticky_bkpt_clear_pulse && !warm_reset_pulse)
      else $error("request pulse longer than one cycle");
   undef_state_a: assert property (instr_undefined |-> in_debug_state)
      else $error("instruction undefined outside debug state");
   fault_cause_a: assert property (fault_to_os_level |-> in_debug_state && hyp_mpu_fault)
      else $error("fault redirected without cause");
   fault_code_a: assert property (data_fault_status ==
      (fault_to_os_level ? `DAH_DATA_FAULT_STATUS_DEBUG : 5'h00))
      else $error("fault status code wrong");
   step_valid_a: assert property (step_into |-> step_event_valid)
      else $error("step into without step event");
   lock_err_a: assert property ($rose(s_axi_bvalid) && s_axi_bresp == `DAH_RESP_SLVERR |->
      $stable(oslock_q) ##1 $stable(oslock_q))
      else $error("lock changed on refused write");
endmodule
bind dah_top dah_top_props props (.sys_clk, .reset_n, .debug_enable_in, .hyp_inv_enable_in,
   .in_debug_state, .current_level, .trap_general_exceptions, .hyp_mpu_fault,
   .hyp_irq_pending, .step_event_valid, .s_axi_bresp, .s_axi_bvalid, .halting_allowed,
   .step_into, .instr_undefined, .fault_to_os_level, .data_fault_status, .hyp_irq_masked,
   .sticky_bkpt_clear_pulse, .warm_reset_pulse, .oslock_q);
`default_nettype wire

// File: bench/dah_top_tb_top.sv
// Register-level testbench for the authentication and halting block
`default_nettype none
`include "dah_defs.svh"
module dah_top_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic sys_clk = 1'b0, reset_n = 1'b0;
   logic [3:0] auth = 4'h0;
   logic debug_enable_in, noninv_enable_in, hyp_inv_enable_in, hyp_noninv_enable_in;
   logic in_debug_state = 1'b0, trap_general_exceptions = 1'b0, hyp_trap_configured = 1'b0;
   logic is_debug_change_to_hyp_instr = 1'b0, hyp_mpu_fault = 1'b0, hyp_irq_pending = 1'b0;
   logic step_event_valid = 1'b0;
   logic [1:0] current_level = 2'h1, step_target_level = 2'h0;
   logic [2:0] step_event = 3'h0;
   logic halting_allowed, step_into, instr_undefined, fault_to_os_level, hyp_irq_masked;
   logic trap_debug_access_eff, sticky_bkpt_clear_pulse, warm_reset_pulse, oslock_q;
   logic [4:0] data_fault_status;
   logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
   logic [3:0] s_axi_wstrb = 4'h0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, resp;
   logic d, h;
   logic [7:0] e;
   // Step cases: event, target level, hyp permission, expected syndrome
   logic [7:0] steps [10] = '{8'h01, 8'h15, 8'h1b, 8'h18, 8'h29, 8'h35, 8'h3b, 8'h38,
      8'h49, 8'h56};
   int failures = 0, checks = 0, bk_cnt = 0, wr_cnt = 0, i;
   dah_auth_drv drv (.sys_clk, .setting(auth), .debug_enable_in, .noninv_enable_in,
      .hyp_inv_enable_in, .hyp_noninv_enable_in);
   dah_top dut (.sys_clk, .reset_n, .debug_enable_in, .noninv_enable_in, .hyp_inv_enable_in,
      .hyp_noninv_enable_in, .in_debug_state, .current_level, .trap_general_exceptions,
      .hyp_trap_configured, .is_debug_change_to_hyp_instr, .hyp_mpu_fault, .hyp_irq_pending,
      .step_event_valid, .step_event, .step_target_level, .halting_allowed, .step_into,
      .instr_undefined, .fault_to_os_level, .data_fault_status, .hyp_irq_masked,
      .trap_debug_access_eff, .sticky_bkpt_clear_pulse, .warm_reset_pulse, .oslock_q,
      .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready);
   always #50 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      if (sticky_bkpt_clear_pulse === 1'b1) bk_cnt <= bk_cnt + 1;
      if (warm_reset_pulse === 1'b1) wr_cnt <= wr_cnt + 1;
   end
   task automatic stop_test();
      if (failures == 0 && checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic guard(inout int n);
      n++;
      if (n > 100) begin
         failures++;
         stop_test();
      end
   endtask
   // Ready and valid are sampled mid-cycle; release follows the taking edge
   task automatic axi_write(input logic [11:0] a, input logic [31:0] v, output logic [1:0] r);
      int n;
      logic aw_d, w_d, b_d, a_go, w_go;
      n = 0; aw_d = 0; w_d = 0; b_d = 0;
      @(posedge sys_clk);
      s_axi_awaddr <= a; s_axi_awvalid <= 1'b1; s_axi_wdata <= v;
      s_axi_wstrb <= 4'hf; s_axi_wvalid <= 1'b1; s_axi_bready <= 1'b1;
      while (!b_d) begin
         @(negedge sys_clk);
         guard(n);
         a_go = !aw_d && s_axi_awready === 1'b1;
         w_go = !w_d && s_axi_wready === 1'b1;
         if (s_axi_bvalid === 1'b1) begin b_d = 1; r = s_axi_bresp; end
         @(posedge sys_clk);
         if (a_go) begin aw_d = 1; s_axi_awvalid <= 1'b0; end
         if (w_go) begin w_d = 1; s_axi_wvalid <= 1'b0; end
      end
      s_axi_bready <= 1'b0;
   endtask
   task automatic axi_read(input logic [11:0] a, output logic [31:0] v, output logic [1:0] r);
      int n;
      logic ar_d, r_d, a_go;
      n = 0; ar_d = 0; r_d = 0;
      @(posedge sys_clk);
      s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
      while (!r_d) begin
         @(negedge sys_clk);
         guard(n);
         a_go = !ar_d && s_axi_arready === 1'b1;
         if (s_axi_rvalid === 1'b1) begin r_d = 1; v = s_axi_rdata; r = s_axi_rresp; end
         @(posedge sys_clk);
         if (a_go) begin ar_d = 1; s_axi_arvalid <= 1'b0; end
      end
      s_axi_rready <= 1'b0;
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge sys_clk);
      @(negedge sys_clk);
   endtask
   // Driver register plus two synchroniser stages, with margin
   task automatic set_auth(input logic [3:0] v);
      @(posedge sys_clk);
      auth <= v;
      settle(6);
   endtask
   initial begin
      repeat (4) @(posedge sys_clk);
      reset_n <= 1'b1;
      for (i = 0; i < 16; i++) begin
         set_auth(i[3:0]);
         d = i[0];
         h = i[0] & i[2];
         axi_read(`DAH_OFS_STATUS, rd, resp);
         check("perm", rd[3:0], {(d | i[1]) & (i[2] | i[3]), h, d | i[1], d});
         check("hdd_run", rd[4], !h);
         check("halt_os", halting_allowed, d);
         @(posedge sys_clk) current_level <= 2'h2;
         @(negedge sys_clk) check("halt_hyp", halting_allowed, h);
         @(posedge sys_clk) begin current_level <= 2'h1; trap_general_exceptions <= 1'b1; end
         @(negedge sys_clk) check("halt_tge", halting_allowed, h);
         @(posedge sys_clk) trap_general_exceptions <= 1'b0;
      end
      hyp_irq_pending <= 1'b1;
      for (i = 0; i < 2; i++) begin
         set_auth(i ? 4'h5 : 4'h1);
         axi_write(`DAH_OFS_CTRL, 32'h3, resp);
         check("ctrl_resp", resp, `DAH_RESP_OKAY);
         axi_write(`DAH_OFS_REQ, 32'h3, resp);
         settle(3);
         check("bkpt_pulses", bk_cnt, i);
         check("warm_pulses", wr_cnt, i);
         @(posedge sys_clk) current_level <= 2'h2;
         @(negedge sys_clk) check("irq_mask", hyp_irq_masked, i);
         check("tda_hyp", trap_debug_access_eff, i);
         @(posedge sys_clk) current_level <= 2'h1;
         @(negedge sys_clk) check("tda_os", trap_debug_access_eff, 1);
      end
      set_auth(4'h1);
      @(posedge sys_clk) in_debug_state <= 1'b1;
      settle(2);
      axi_read(`DAH_OFS_STATUS, rd, resp);
      check("hdd_entry", rd[4], 1);
      set_auth(4'h5);
      axi_read(`DAH_OFS_STATUS, rd, resp);
      check("hdd_frozen", rd[4], 1);
      @(posedge sys_clk) begin is_debug_change_to_hyp_instr <= 1'b1; hyp_mpu_fault <= 1'b1; end
      @(negedge sys_clk) check("undef_dcps", instr_undefined, 1);
      check("fault_os", fault_to_os_level, 1);
      check("fault_code", data_fault_status, `DAH_DATA_FAULT_STATUS_DEBUG);
      @(posedge sys_clk) begin is_debug_change_to_hyp_instr <= 1'b0; hyp_trap_configured <= 1'b1; end
      @(negedge sys_clk) check("undef_trap", instr_undefined, 1);
      @(posedge sys_clk) begin in_debug_state <= 1'b0; hyp_trap_configured <= 1'b0; end
      set_auth(4'h1);
      @(posedge sys_clk) current_level <= 2'h2;
      @(posedge sys_clk) in_debug_state <= 1'b1;
      settle(2);
      axi_read(`DAH_OFS_STATUS, rd, resp);
      check("hdd_at_hyp", rd[4], 0);
      check("fault_kept", fault_to_os_level, 0);
      @(posedge sys_clk) begin in_debug_state <= 1'b0; hyp_mpu_fault <= 1'b0; end
      @(posedge sys_clk) current_level <= 2'h1;
      set_auth(4'h0);
      axi_write(`DAH_OFS_OSLOCK, 32'h1, resp);
      check("lock_refused", resp, `DAH_RESP_SLVERR);
      axi_read(`DAH_OFS_OSLOCK, rd, resp);
      check("lock_unset", rd[0], 0);
      set_auth(4'h1);
      axi_write(`DAH_OFS_OSLOCK, 32'h1, resp);
      check("lock_ok", resp, `DAH_RESP_OKAY);
      check("lock_set", oslock_q, 1);
      axi_read(12'h100, rd, resp);
      check("unmapped", resp, `DAH_RESP_DECERR);
      for (i = 0; i < 10; i++) begin
         e = steps[i];
         @(posedge sys_clk) reset_n <= 1'b0;
         repeat (2) @(posedge sys_clk);
         reset_n <= 1'b1;
         set_auth({1'b0, e[1], 2'b01});
         @(posedge sys_clk) begin
            step_event <= e[6:4]; step_target_level <= e[3:2]; step_event_valid <= 1'b1;
         end
         @(negedge sys_clk) check("step_into", step_into, e[3:2] != 2'h2 || e[1]);
         @(posedge sys_clk) step_event_valid <= 1'b0;
         settle(1);
         axi_read(`DAH_OFS_SYND, rd, resp);
         check("syndrome", rd[0], e[0]);
         axi_read(`DAH_OFS_EVENT, rd, resp);
         check("last_event", rd[2:0], e[6:4]);
      end
      stop_test();
   end
endmodule
`default_nettype wire
